/* verilog/tie_defs.vh */
`ifndef TIE_DEFS_VH
`define TIE_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TIE_OFS_PAGE_GRAIN 8'h00
`define TIE_OFS_CFG_THREE 8'h04
`define TIE_OFS_CTX_MASK 8'h08
`define TIE_OFS_CONTEXT 8'h0c
`define TIE_OFS_FAULT_VADDR 8'h10
`define TIE_OFS_ENTRY_HI 8'h14
`define TIE_OFS_ENTRY_LO_EVEN 8'h18
`define TIE_OFS_ENTRY_LO_ODD 8'h1c
`define TIE_OFS_EXC_CODE 8'h20
`define TIE_OFS_EXC_BASE 8'h24
`define TIE_OFS_INT_STATUS 8'h28
`define TIE_OFS_INT_MASK 8'h2c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TIE_PG_INHIBIT_EN 30
`define TIE_PG_CODE_SEL 27
`define TIE_CFG3_CTX_EN 0
`define TIE_CTX_PAGE_HI 22
`define TIE_CTX_PAGE_LO 4
`define TIE_VA_PAGE_HI 31
`define TIE_VA_PAGE_LO 13
`define TIE_EHI_ADDRESS_SPACE_ID_HI 7
`define TIE_EHI_ADDRESS_SPACE_ID_LO 0
`define TIE_IRQ_EXEC 0
`define TIE_IRQ_READ 1

// ----------------------------------------------------------------
// codes, vectors and reset values
// ----------------------------------------------------------------
`define TIE_CODE_TLB_LOAD 5'h02
`define TIE_CODE_TLB_INHIBIT 5'h14
`define TIE_GEN_VECTOR_OFS 32'h00000180
`define TIE_RST_EXC_BASE 32'h80000000
`define TIE_RST_ZERO 32'h00000000
`define TIE_RESP_OKAY 2'b00
`define TIE_RESP_SLVERR 2'b10

`endif

/* verilog/tie_inhibit_detect.v */
`timescale 1ns/10ps
`include "tie_defs.vh"

module tie_inhibit_detect
#(
  parameter INHIBIT_IMPL = 1
)
(
  // fetch lookup
  input wire fetchValid,
  input wire fetchHit,
  input wire fetchNoExec,
  // load lookup
  input wire loadValid,
  input wire loadHit,
  input wire loadNoRead,
  input wire loadPcRel16,
  // control bits
  input wire inhibitEnable,
  input wire codeSelect,
  // decision
  output wire execFault,
  output wire readFault,
  output wire [4:0] exception_code_field
);

  wire allowed;

  assign allowed = (INHIBIT_IMPL != 0) && inhibitEnable;
  assign execFault = allowed && fetchValid && fetchHit &&
    fetchNoExec;
  // compact pc-relative loads ignore the read-inhibit bit
  assign readFault = allowed && loadValid && loadHit && loadNoRead &&
    !loadPcRel16;
  assign exception_code_field = codeSelect ? `TIE_CODE_TLB_INHIBIT :
    `TIE_CODE_TLB_LOAD;

endmodule

/* verilog/tie_ctx_build.v */
`timescale 1ns/10ps
`include "tie_defs.vh"

module tie_ctx_build
(
  // inputs
  input wire [31:0] ctxOld,
  input wire [31:0] vaddr,
  input wire [31:0] indexMask,
  input wire ctxEnable,
  // result
  output wire [31:0] ctxNew
);

  // set mask bits, highest first, take va bits from bit 31 downward
  function [31:0] scatter;
    input [31:0] old;
    input [31:0] va;
    input [31:0] mask;
    integer i;
    integer k;
    begin
      scatter = old;
      k = 31;
      for (i = 31; i >= 0; i = i - 1)
      begin
        if (mask[i])
        begin
          scatter[i] = va[k];
          k = k - 1;
        end
      end
    end
  endfunction

  reg [31:0] plain;

  always @*
  begin
    plain = ctxOld;
    plain[`TIE_CTX_PAGE_HI:`TIE_CTX_PAGE_LO] =
      vaddr[`TIE_VA_PAGE_HI:`TIE_VA_PAGE_LO];
  end

  assign ctxNew = ctxEnable ? scatter(ctxOld, vaddr, indexMask) :
    plain;

endmodule

/* verilog/tie_inhibit_exc.v */
`timescale 1ns/10ps
`include "tie_defs.vh"

module tie_inhibit_exc
#(
  parameter INHIBIT_IMPL = 1,
  parameter ADDRESS_SPACE_ID_W = 8
)
(
  // clock and reset
  input wire clock,
  input wire nrst,
  // fetch stage lookup
  input wire fetchValid,
  input wire [31:0] fetchVaddr,
  input wire [ADDRESS_SPACE_ID_W-1:0] fetchAsid,
  input wire fetchTlbHit,
  input wire fetchTlbNoExec,
  // load stage lookup
  input wire loadValid,
  input wire [31:0] loadVaddr,
  input wire [ADDRESS_SPACE_ID_W-1:0] loadAsid,
  input wire loadTlbHit,
  input wire loadTlbNoRead,
  input wire loadPcRel16,
  // exception to pipeline
  output reg excTake_r,
  output reg excIsRead_r,
  output reg [4:0] exception_code_field_r,
  output reg [31:0] redirectPc_r,
  // interrupt
  output wire irq,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [31:0] strobeMerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      strobeMerge = old;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (strb[b])
          strobeMerge[b*8 +: 8] = data[b*8 +: 8];
      end
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'b00) && (addr <= `TIE_OFS_INT_MASK);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [31:0] page_granule_reg_r;
  reg [31:0] cfgThree_r;
  reg [31:0] ctxMask_r;
  reg [31:0] context_r;
  reg [31:0] faultVaddr_r;
  reg [31:0] tlb_entry_high_reg_r;
  reg [31:0] entryLoEven_r;
  reg [31:0] entryLoOdd_r;
  reg [31:0] excBase_r;
  reg [1:0] intStatus_r;
  reg [1:0] intMask_r;

  wire execFault;
  wire readFault;
  wire anyFault;
  wire [4:0] codeNxt;
  wire [31:0] faultVa;
  wire [ADDRESS_SPACE_ID_W-1:0] faultAsid;
  wire [31:0] contextNxt;
  wire [31:0] entryHiNxt;
  wire wrFire;
  wire rdFire;
  wire [31:0] wrOld;
  wire [31:0] wrVal;
  wire [1:0] statusSet;

  // ----------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------
  tie_inhibit_detect #(
    .INHIBIT_IMPL(INHIBIT_IMPL)
  ) uDetect (
    .fetchValid(fetchValid),
    .fetchHit(fetchTlbHit),
    .fetchNoExec(fetchTlbNoExec),
    .loadValid(loadValid),
    .loadHit(loadTlbHit),
    .loadNoRead(loadTlbNoRead),
    .loadPcRel16(loadPcRel16),
    .inhibitEnable(page_granule_reg_r[`TIE_PG_INHIBIT_EN]),
    .codeSelect(page_granule_reg_r[`TIE_PG_CODE_SEL]),
    .execFault(execFault),
    .readFault(readFault),
    .exception_code_field(codeNxt)
  );

  // the load is the older instruction, so it wins a same-cycle tie
  assign anyFault = execFault || readFault;
  assign faultVa = readFault ? loadVaddr : fetchVaddr;
  assign faultAsid = readFault ? loadAsid : fetchAsid;

  tie_ctx_build uCtx (
    .ctxOld(context_r),
    .vaddr(faultVa),
    .indexMask(ctxMask_r),
    .ctxEnable(cfgThree_r[`TIE_CFG3_CTX_EN]),
    .ctxNew(contextNxt)
  );

  assign entryHiNxt = {faultVa[`TIE_VA_PAGE_HI:`TIE_VA_PAGE_LO],
    {(`TIE_VA_PAGE_LO - ADDRESS_SPACE_ID_W){1'b0}}, faultAsid};
  assign statusSet = {readFault, execFault && !readFault};

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrFire = s_axi_awready;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign irq = |(intStatus_r & intMask_r);

  reg [31:0] wrOldSel;
  always @*
  begin
    case (s_axi_awaddr)
      `TIE_OFS_PAGE_GRAIN: wrOldSel = page_granule_reg_r;
      `TIE_OFS_CFG_THREE: wrOldSel = cfgThree_r;
      `TIE_OFS_CTX_MASK: wrOldSel = ctxMask_r;
      `TIE_OFS_CONTEXT: wrOldSel = context_r;
      `TIE_OFS_ENTRY_HI: wrOldSel = tlb_entry_high_reg_r;
      `TIE_OFS_ENTRY_LO_EVEN: wrOldSel = entryLoEven_r;
      `TIE_OFS_ENTRY_LO_ODD: wrOldSel = entryLoOdd_r;
      `TIE_OFS_EXC_BASE: wrOldSel = excBase_r;
      `TIE_OFS_INT_MASK: wrOldSel = {30'h0, intMask_r};
      default: wrOldSel = `TIE_RST_ZERO;
    endcase
  end
  assign wrOld = wrOldSel;
  assign wrVal = strobeMerge(wrOld, s_axi_wdata, s_axi_wstrb);

  // ----------------------------------------------------------------
  // register writes and exception capture
  // ----------------------------------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      page_granule_reg_r <= `TIE_RST_ZERO;
      cfgThree_r <= `TIE_RST_ZERO;
      ctxMask_r <= `TIE_RST_ZERO;
      context_r <= `TIE_RST_ZERO;
      faultVaddr_r <= `TIE_RST_ZERO;
      tlb_entry_high_reg_r <= `TIE_RST_ZERO;
      entryLoEven_r <= `TIE_RST_ZERO;
      entryLoOdd_r <= `TIE_RST_ZERO;
      excBase_r <= `TIE_RST_EXC_BASE;
      intStatus_r <= 2'h0;
      intMask_r <= 2'h0;
      excTake_r <= 1'b0;
      excIsRead_r <= 1'b0;
      exception_code_field_r <= 5'h00;
      redirectPc_r <= `TIE_RST_ZERO;
    end
    else
    begin
      excTake_r <= anyFault;
      if (anyFault)
      begin
        excIsRead_r <= readFault;
        exception_code_field_r <= codeNxt;
        redirectPc_r <= excBase_r + `TIE_GEN_VECTOR_OFS;
      end
      // software writes; a fault in the same cycle overrides below
      if (wrFire)
      begin
        case (s_axi_awaddr)
          `TIE_OFS_PAGE_GRAIN: page_granule_reg_r <= wrVal;
          `TIE_OFS_CFG_THREE: cfgThree_r <= wrVal;
          `TIE_OFS_CTX_MASK: ctxMask_r <= wrVal;
          `TIE_OFS_CONTEXT: context_r <= wrVal;
          `TIE_OFS_ENTRY_HI: tlb_entry_high_reg_r <= wrVal;
          `TIE_OFS_ENTRY_LO_EVEN: entryLoEven_r <= wrVal;
          `TIE_OFS_ENTRY_LO_ODD: entryLoOdd_r <= wrVal;
          `TIE_OFS_EXC_BASE: excBase_r <= wrVal;
          `TIE_OFS_INT_MASK: intMask_r <= wrVal[1:0];
          default: ;
        endcase
      end
      // entry-low registers are not touched by a fault
      if (anyFault)
      begin
        faultVaddr_r <= faultVa;
        context_r <= contextNxt;
        tlb_entry_high_reg_r <= entryHiNxt;
      end
      // a new event wins over a write-one clear in the same cycle
      if (wrFire && s_axi_awaddr == `TIE_OFS_INT_STATUS &&
          s_axi_wstrb[0])
        intStatus_r <= (intStatus_r & ~s_axi_wdata[1:0]) | statusSet;
      else
        intStatus_r <= intStatus_r | statusSet;
    end
  end

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  reg [31:0] rdSel;
  always @*
  begin
    case (s_axi_araddr)
      `TIE_OFS_PAGE_GRAIN: rdSel = page_granule_reg_r;
      `TIE_OFS_CFG_THREE: rdSel = cfgThree_r;
      `TIE_OFS_CTX_MASK: rdSel = ctxMask_r;
      `TIE_OFS_CONTEXT: rdSel = context_r;
      `TIE_OFS_FAULT_VADDR: rdSel = faultVaddr_r;
      `TIE_OFS_ENTRY_HI: rdSel = tlb_entry_high_reg_r;
      `TIE_OFS_ENTRY_LO_EVEN: rdSel = entryLoEven_r;
      `TIE_OFS_ENTRY_LO_ODD: rdSel = entryLoOdd_r;
      `TIE_OFS_EXC_CODE: rdSel = {25'h0, exception_code_field_r, 2'b00};
      `TIE_OFS_EXC_BASE: rdSel = excBase_r;
      `TIE_OFS_INT_STATUS: rdSel = {30'h0, intStatus_r};
      `TIE_OFS_INT_MASK: rdSel = {30'h0, intMask_r};
      default: rdSel = `TIE_RST_ZERO;
    endcase
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TIE_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TIE_RESP_OKAY;
      s_axi_rdata <= `TIE_RST_ZERO;
    end
    else
    begin
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(s_axi_awaddr) ? `TIE_RESP_OKAY :
          `TIE_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdSel;
        s_axi_rresp <= mapped(s_axi_araddr) ? `TIE_RESP_OKAY :
          `TIE_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* tb/tie_inhibit_exc_assertions.sv */
`timescale 1ns/10ps
module tie_inhibit_exc_checker
(
  // clock and reset
  input wire clock,
  input wire nrst,
  // lookups
  input wire fetchValid,
  input wire fetchTlbHit,
  input wire fetchTlbNoExec,
  input wire loadValid,
  input wire loadTlbHit,
  input wire loadTlbNoRead,
  input wire loadPcRel16,
  // exception
  input wire excTake_r,
  input wire excIsRead_r,
  input wire [4:0] exception_code_field_r,
  input wire [31:0] redirectPc_r,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp
);
  wire fFlt = fetchValid & fetchTlbHit & fetchTlbNoExec;
  wire lFlt = loadValid & loadTlbHit & loadTlbNoRead & ~loadPcRel16;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence sFault; fFlt | lFlt; endsequence
  sequence sQuiet; !(fFlt | lFlt); endsequence
  a_take_cause:
    assert property (excTake_r |-> $past(fFlt | lFlt))
    else $error("exception without a fault");
  a_read_kind:
    assert property (excTake_r |-> excIsRead_r == $past(lFlt))
    else $error("wrong exception kind");
  a_take_pulse:
    assert property (sFault ##1 sQuiet |=> !excTake_r)
    else $error("exception pulse too long");
  a_code_legal:
    assert property (excTake_r |-> exception_code_field_r inside {5'h02, 5'h14})
    else $error("bad exception code");
  a_vec_ofs:
    assert property (excTake_r |-> redirectPc_r[8:0] == 9'h180)
    else $error("bad vector offset");
  a_vec_hold:
    assert property (!excTake_r |-> $stable(redirectPc_r))
    else $error("vector moved without exception");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
      |=> s_axi_bvalid)
    else $error("no write response");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_bad_read:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2c
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

/* tb/tie_pipe_model.sv */
`timescale 1ns/10ps
module tie_pipe_model
(
  // clock
  input wire clock,
  // fetch lookup
  output logic fetchValid,
  output logic [31:0] fetchVaddr,
  output logic [7:0] fetchAsid,
  output logic fetchTlbHit,
  output logic fetchTlbNoExec,
  // load lookup
  output logic loadValid,
  output logic [31:0] loadVaddr,
  output logic [7:0] loadAsid,
  output logic loadTlbHit,
  output logic loadTlbNoRead,
  output logic loadPcRel16
);
  // one lookup cycle; idle addresses are scrambled; m[4] makes both miss
  task automatic look(input logic [4:0] m, input logic [31:0] fa, la);
    @(posedge clock);
    fetchValid <= m[3];
    loadValid <= m[2];
    fetchTlbHit <= !m[4];
    loadTlbHit <= !m[4];
    fetchTlbNoExec <= m[1];
    loadTlbNoRead <= m[1];
    loadPcRel16 <= m[0];
    fetchVaddr <= fa;
    loadVaddr <= la;
    fetchAsid <= fa[7:0];
    loadAsid <= la[7:0];
    @(posedge clock);
    fetchValid <= 1'h0;
    loadValid <= 1'h0;
    fetchVaddr <= ~fa;
    loadVaddr <= ~la;
    fetchAsid <= ~fa[7:0];
    loadAsid <= ~la[7:0];
  endtask
  initial
  begin
    {fetchValid, loadValid, fetchTlbNoExec, loadTlbNoRead} = 4'h0;
    {fetchTlbHit, loadTlbHit, loadPcRel16} = 3'h0;
    {fetchVaddr, loadVaddr} = {32'h5a5a5a5a, 32'ha5a5a5a5};
    {fetchAsid, loadAsid} = 16'h33cc;
  end
endmodule

/* tb/tb_tie_inhibit_exc.sv */
`timescale 1ns/10ps
`include "tie_defs.vh"
module tb_tie_inhibit_exc;
  localparam logic [31:0] VA1 = 32'hdeade0a5;
  localparam logic [31:0] VA2 = 32'h12345678;
  localparam logic [31:0] VA3 = 32'hfedcb9e1;
  localparam logic [31:0] VA4 = 32'ha5a50f3c;
  logic clock, nrst, fetchValid, fetchTlbNoExec, loadValid, loadTlbNoRead;
  logic loadPcRel16, excTake_r, excIsRead_r, irq, fetchTlbHit, loadTlbHit;
  logic [31:0] fetchVaddr, loadVaddr, redirectPc_r, rdat;
  logic [7:0] fetchAsid, loadAsid, s_axi_awaddr, s_axi_araddr;
  logic [4:0] exception_code_field_r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  int error_cnt, samples_checked;
  tie_pipe_model pm (.clock, .fetchValid, .fetchVaddr, .fetchAsid,
    .fetchTlbHit, .fetchTlbNoExec, .loadValid, .loadVaddr, .loadAsid,
    .loadTlbHit, .loadTlbNoRead, .loadPcRel16);
  tie_inhibit_exc DUT (.clock, .nrst, .fetchValid, .fetchVaddr,
    .fetchAsid, .fetchTlbHit, .fetchTlbNoExec, .loadValid, .loadVaddr,
    .loadAsid, .loadTlbHit, .loadTlbNoRead, .loadPcRel16, .excTake_r,
    .excIsRead_r, .exception_code_field_r, .redirectPc_r, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do @(posedge clock); while (!s_axi_awready);
    chk({31'h0, s_axi_wready}, 32'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    brsp = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  // lookup mode m is {miss, fetch, load, inhibit bit, pc-relative}
  task lk(input logic [4:0] m, input logic [31:0] fa, la, input logic t);
    pm.look(m, fa, la);
    #1;
    chk({31'h0, excTake_r}, {31'h0, t});
  endtask
  task st(input logic [31:0] va, input logic [4:0] c, input logic r);
    chk({27'h0, exception_code_field_r}, {27'h0, c});
    chk({31'h0, excIsRead_r}, {31'h0, r});
    chk(redirectPc_r, `TIE_RST_EXC_BASE + `TIE_GEN_VECTOR_OFS);
    rdchk(`TIE_OFS_FAULT_VADDR, va);
    rdchk(`TIE_OFS_ENTRY_HI, {va[31:13], 5'h0, va[7:0]});
    rdchk(`TIE_OFS_EXC_CODE, {25'h0, c, 2'h0});
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    #(50 * 5000);
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'h1;
    rdchk(`TIE_OFS_EXC_BASE, `TIE_RST_EXC_BASE);
    rdchk(`TIE_OFS_PAGE_GRAIN, 32'h0);
    rd(8'h30);
    chk({30'h0, rrsp}, {30'h0, `TIE_RESP_SLVERR});
    wr(8'h30, 32'h0);
    chk({30'h0, brsp}, {30'h0, `TIE_RESP_SLVERR});
    wr(`TIE_OFS_INT_MASK, 32'h3);
    chk({30'h0, brsp}, {30'h0, `TIE_RESP_OKAY});
    lk(5'h0a, VA1, VA2, 1'h0);
    wr(`TIE_OFS_PAGE_GRAIN, 32'h40000000);
    lk(5'h08, VA1, VA2, 1'h0);
    lk(5'h1a, VA1, VA2, 1'h0);
    lk(5'h0a, VA1, VA2, 1'h1);
    chk({31'h0, irq}, 32'h1);
    st(VA1, `TIE_CODE_TLB_LOAD, 1'h0);
    rdchk(`TIE_OFS_CONTEXT, {9'h0, VA1[31:13], 4'h0});
    rdchk(`TIE_OFS_INT_STATUS, 32'h1);
    wr(`TIE_OFS_INT_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`TIE_OFS_PAGE_GRAIN, 32'h48000000);
    lk(5'h07, VA1, VA2, 1'h0);
    lk(5'h04, VA1, VA2, 1'h0);
    lk(5'h16, VA1, VA2, 1'h0);
    lk(5'h0e, VA1, VA3, 1'h1);
    st(VA3, `TIE_CODE_TLB_INHIBIT, 1'h1);
    rdchk(`TIE_OFS_INT_STATUS, 32'h2);
    lk(5'h0a, VA4, VA2, 1'h1);
    st(VA4, `TIE_CODE_TLB_INHIBIT, 1'h0);
    wr(`TIE_OFS_CFG_THREE, 32'h1);
    wr(`TIE_OFS_CTX_MASK, 32'hf0);
    lk(5'h06, VA1, VA2, 1'h1);
    st(VA2, `TIE_CODE_TLB_INHIBIT, 1'h1);
    rdchk(`TIE_OFS_CONTEXT, {9'h0, VA4[31:13], 4'h0} & 32'hffffff0f
      | {24'h0, VA2[31:28], 4'h0});
    report_and_stop;
  end
endmodule
bind tie_inhibit_exc tie_inhibit_exc_checker chk_i (.clock, .nrst,
  .fetchValid, .fetchTlbHit, .fetchTlbNoExec, .loadValid, .loadTlbHit,
  .loadTlbNoRead, .loadPcRel16, .excTake_r, .excIsRead_r, .exception_code_field_r,
  .redirectPc_r, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);
